// >>> rtl/mpc_core.sv
// Functional notes
// - Hold load inertia 0.000 to 4000.000, reset value 0.000.
// - Any change of load inertia forces servo gain to zero.
// - Positioning acceleration accepts 0.1 to 800.0, reset value 1.0.
// - Positioning deceleration 0.1 to 800.0, or 0.0 meaning reuse acceleration.
// - On stop input or halt command apply larger of current and halt deceleration.
// - Halt deceleration 0.0 means use running operation's deceleration; else 0.1 to 800.0.
// - Read-identity command reports compatible motor type and firmware version.
// - Paged readout 1 (reset) pauses after each line but the last awaiting a key.
// - Paged readout 0 sends all lines without pausing.
// - While paused, space gives next line, backspace ends the readout.
// - Monitor select codes 0 to 8 pick the monitored quantity, reset 0.
// - Changing monitor select reloads its offset and span values.
// - A named parameter as select routes that parameter to the monitor.
// - Monitor span resets to 10.000, offset to 0.000, limits are the same for every select.
// - Motor-off blocks servo until servo-on command; then the input rules again.
// - Readout interval 0.0 to 10000.0 ms minimum gap; -1 resets the gap timer.
// - Halt stops positioning, jogging, home return and programmed operation.
// - Positioning speed accepts 0.001 to 10.000, reset value 1.000.
// - Positioning speed changes reach the speed output at once.
`timescale 1ns/1ns
`default_nettype none

module mpc_core #(
  parameter int          CYC_PER_UNIT = mpc_pkg::CYC_PER_UNIT,
  parameter logic [15:0] MOTOR_TYPE   = 16'h0001, // Arbitrary value
  parameter logic [15:0] FW_VERSION   = 16'h0100  // Arbitrary value
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // Pins
  input  wire logic         stop_input,
  input  wire logic         servo_enable_input,
  // Motion logic status
  input  wire logic         positioning_busy,
  input  wire logic         jog_busy,
  input  wire logic         home_busy,
  input  wire logic         program_busy,
  input  wire logic [31:0]  cur_op_decel,
  input  wire logic [143:0] mon_quantity,
  // Motion settings
  output logic              servo_on,
  output logic              halt_request,
  output logic [31:0]       applied_decel,
  output logic [31:0]       inertia_setting,
  output logic [31:0]       servo_gain,
  output logic [31:0]       accel_for_moves,
  output logic [31:0]       decel_for_moves,
  output logic [31:0]       positioning_speed,
  // Analog monitor
  output logic [8:0]        first_analog_select,
  output logic [31:0]       first_monitor_offset,
  output logic [31:0]       first_monitor_span,
  output logic [31:0]       first_analog_output,
  // Readout line engine
  output logic              line_strobe,
  output logic [7:0]        line_index
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
    logic [1:0]          stop_sync;
    logic [1:0]          servo_enable_input_sync;
    logic [31:0]         inertia;
    logic [31:0]         gain;
    logic [31:0]         accel;
    logic [31:0]         decel;
    logic [31:0]         halt_decel;
    logic                paged;
    logic [8:0]          mon_sel;
    logic [31:0]         mon_off;
    logic [31:0]         mon_span;
    logic [31:0]         interval;
    logic [31:0]         speed;
    logic                locked;
    logic                servo_on;
    logic                halting;
    logic [31:0]         applied;
    logic                id_valid;
    logic [31:0]         identity;
    logic                range_err;
    logic [31:0]         mon_out;
    mpc_pkg::mpc_rd_type rd_state;
    logic [7:0]          lines_left;
    logic [7:0]          line_idx;
    logic                strobe;
    logic [47:0]         gap_cnt;
  } mpc_state_type;

  mpc_state_type st_ff;
  mpc_state_type nxt_st;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic in_range(input logic [31:0] v, lo, hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range
  function automatic logic [31:0] max_decel(input logic [31:0] a, b);
    max_decel = (a > b) ? a : b;
  endfunction : max_decel
  function automatic logic [31:0] abs_val(input logic [31:0] v);
    abs_val = v[31] ? (~v + 32'h0000_0001) : v;
  endfunction : abs_val
  // ---------------------------------------------------------------
  // Combinational next state
  // ---------------------------------------------------------------
  logic        setup_ph, wr_take, mapped, wr_ok, halt_cmd, any_motion, gap_done;
  logic [31:0] rd_val, move_decel, op_decel, named_val, status;
  logic [47:0] gap_need;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.strobe = 1'b0;
    nxt_st.stop_sync = {st_ff.stop_sync[0], stop_input};
    nxt_st.servo_enable_input_sync = {st_ff.servo_enable_input_sync[0], servo_enable_input};
    move_decel = (st_ff.decel == 32'h0000_0000) ? st_ff.accel : st_ff.decel;
    case (st_ff.mon_sel[7:0])
      8'h00:   named_val = st_ff.inertia;
      8'h01:   named_val = st_ff.gain;
      8'h02:   named_val = st_ff.accel;
      8'h03:   named_val = st_ff.decel;
      8'h04:   named_val = st_ff.halt_decel;
      8'h05:   named_val = {31'h0, st_ff.paged};
      8'h06:   named_val = st_ff.mon_off;
      8'h07:   named_val = st_ff.mon_span;
      8'h08:   named_val = st_ff.interval;
      8'h09:   named_val = st_ff.speed;
      8'h0a:   named_val = st_ff.applied;
      default: named_val = 32'h0000_0000;
    endcase
    status = {16'h0, st_ff.lines_left, st_ff.stop_sync[1], st_ff.range_err,
              (st_ff.rd_state == mpc_pkg::RD_WAIT), (st_ff.rd_state != mpc_pkg::RD_IDLE),
              st_ff.id_valid, st_ff.halting, st_ff.locked, st_ff.servo_on};
    // Decode at setup, answer registered for the access phase
    setup_ph = psel && !penable && !st_ff.pready;
    mapped = (paddr[1:0] == 2'b00) && (paddr <= mpc_pkg::ADDR_APPLIED);
    case (paddr)
      mpc_pkg::ADDR_INERTIA:    wr_ok = (pwdata <= mpc_pkg::INERTIA_MAX);
      mpc_pkg::ADDR_GAIN:       wr_ok = (pwdata <= mpc_pkg::GAIN_MAX);
      mpc_pkg::ADDR_ACCEL:      wr_ok = in_range(pwdata, mpc_pkg::ACC_MIN, mpc_pkg::ACC_MAX);
      mpc_pkg::ADDR_DECEL,
      mpc_pkg::ADDR_HALT_DECEL: wr_ok = (pwdata <= mpc_pkg::ACC_MAX);
      mpc_pkg::ADDR_PAGED:      wr_ok = (pwdata[31:1] == 31'h0);
      mpc_pkg::ADDR_MON_SEL:    wr_ok = (pwdata[31:9] == 23'h0) &&
                                        (pwdata[mpc_pkg::MON_NAMED_BIT] ?
                                         (pwdata[7:0] <= mpc_pkg::NAMED_MAX) :
                                         (pwdata[7:0] <= mpc_pkg::MON_CODE_MAX));
      mpc_pkg::ADDR_MON_OFF:    wr_ok = (abs_val(pwdata) <= mpc_pkg::MON_OFF_LIMIT);
      mpc_pkg::ADDR_MON_SPAN:   wr_ok = in_range(pwdata, 32'h0000_0001,
                                                 mpc_pkg::MON_SPAN_MAX);
      mpc_pkg::ADDR_INTERVAL:   wr_ok = (pwdata <= mpc_pkg::INTERVAL_MAX) ||
                                        (pwdata == mpc_pkg::INTERVAL_RESET);
      mpc_pkg::ADDR_SPEED:      wr_ok = in_range(pwdata, mpc_pkg::SPEED_MIN,
                                                 mpc_pkg::SPEED_MAX);
      mpc_pkg::ADDR_COMMAND:    wr_ok = 1'b1;
      mpc_pkg::ADDR_READOUT:    wr_ok = (pwdata[31:8] == 24'h0) && (pwdata[7:0] != 8'h00) &&
                                        (st_ff.rd_state == mpc_pkg::RD_IDLE);
      default:                  wr_ok = 1'b0;
    endcase
    case (paddr)
      mpc_pkg::ADDR_INERTIA:    rd_val = st_ff.inertia;
      mpc_pkg::ADDR_GAIN:       rd_val = st_ff.gain;
      mpc_pkg::ADDR_ACCEL:      rd_val = st_ff.accel;
      mpc_pkg::ADDR_DECEL:      rd_val = st_ff.decel;
      mpc_pkg::ADDR_HALT_DECEL: rd_val = st_ff.halt_decel;
      mpc_pkg::ADDR_PAGED:      rd_val = {31'h0, st_ff.paged};
      mpc_pkg::ADDR_MON_SEL:    rd_val = {23'h0, st_ff.mon_sel};
      mpc_pkg::ADDR_MON_OFF:    rd_val = st_ff.mon_off;
      mpc_pkg::ADDR_MON_SPAN:   rd_val = st_ff.mon_span;
      mpc_pkg::ADDR_INTERVAL:   rd_val = st_ff.interval;
      mpc_pkg::ADDR_SPEED:      rd_val = st_ff.speed;
      mpc_pkg::ADDR_STATUS:     rd_val = status;
      mpc_pkg::ADDR_IDENTITY:   rd_val = st_ff.identity;
      mpc_pkg::ADDR_READOUT:    rd_val = {24'h0, st_ff.line_idx};
      mpc_pkg::ADDR_APPLIED:    rd_val = st_ff.applied;
      default:                  rd_val = 32'h0000_0000;
    endcase
    nxt_st.pready = setup_ph;
    if (setup_ph) begin
      nxt_st.prdata = pwrite ? 32'h0000_0000 : rd_val;
      nxt_st.pslverr = !mapped || (pwrite && !wr_ok);
    end
    // Writes land at the access edge that samples pready high
    wr_take = psel && penable && st_ff.pready && pwrite && !st_ff.pslverr;
    halt_cmd = wr_take && (paddr == mpc_pkg::ADDR_COMMAND) && pwdata[mpc_pkg::CMD_HALT];
    if (wr_take) begin
      case (paddr)
        mpc_pkg::ADDR_INERTIA: begin
          nxt_st.inertia = pwdata;
          if (pwdata != st_ff.inertia) begin
            nxt_st.gain = 32'h0000_0000;
          end
        end
        mpc_pkg::ADDR_GAIN:       nxt_st.gain = pwdata;
        mpc_pkg::ADDR_ACCEL:      nxt_st.accel = pwdata;
        mpc_pkg::ADDR_DECEL:      nxt_st.decel = pwdata;
        mpc_pkg::ADDR_HALT_DECEL: nxt_st.halt_decel = pwdata;
        mpc_pkg::ADDR_PAGED:      nxt_st.paged = pwdata[0];
        mpc_pkg::ADDR_MON_SEL: begin
          nxt_st.mon_sel = pwdata[8:0];
          if (pwdata[8:0] != st_ff.mon_sel) begin
            nxt_st.mon_off = mpc_pkg::MON_OFF_RELOAD;
            nxt_st.mon_span = mpc_pkg::MON_SPAN_RELOAD;
          end
        end
        mpc_pkg::ADDR_MON_OFF:    nxt_st.mon_off = pwdata;
        mpc_pkg::ADDR_MON_SPAN:   nxt_st.mon_span = pwdata;
        mpc_pkg::ADDR_INTERVAL:   nxt_st.interval = (pwdata == mpc_pkg::INTERVAL_RESET) ?
                                                    mpc_pkg::INTERVAL_RST : pwdata;
        mpc_pkg::ADDR_SPEED:      nxt_st.speed = pwdata;
        mpc_pkg::ADDR_COMMAND: begin
          if (pwdata[mpc_pkg::CMD_SERVO_ON]) begin
            nxt_st.locked = 1'b0;
          end
          // Motor-off wins when both are written together: the safe side
          if (pwdata[mpc_pkg::CMD_SERVO_OFF]) begin
            nxt_st.locked = 1'b1;
          end
          if (pwdata[mpc_pkg::CMD_IDENTITY]) begin
            nxt_st.identity = {FW_VERSION, MOTOR_TYPE};
            nxt_st.id_valid = 1'b1;
          end
          if (pwdata[mpc_pkg::CMD_CLR_ERR]) begin
            nxt_st.range_err = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Set wins over a clear written in the same cycle
    if (psel && penable && st_ff.pready && st_ff.pslverr && pwrite) begin
      nxt_st.range_err = 1'b1;
    end
    // Servo and halt
    nxt_st.servo_on = !nxt_st.locked && st_ff.servo_enable_input_sync[1];
    any_motion = positioning_busy || jog_busy || home_busy || program_busy;
    if (st_ff.stop_sync[1] || halt_cmd) begin
      nxt_st.halting = 1'b1;
    end else if (!any_motion) begin
      nxt_st.halting = 1'b0;
    end
    op_decel = positioning_busy ? move_decel : cur_op_decel;
    if (st_ff.halt_decel == 32'h0000_0000) begin
      nxt_st.applied = op_decel;
    end else begin
      nxt_st.applied = max_decel(op_decel, st_ff.halt_decel);
    end
    // Analog monitor source
    if (st_ff.mon_sel[mpc_pkg::MON_NAMED_BIT]) begin
      nxt_st.mon_out = named_val;
    end else begin
      nxt_st.mon_out = {16'h0, mon_quantity[st_ff.mon_sel[3:0]*16 +: 16]};
    end
    // Readout line engine
    gap_need = 48'(st_ff.interval) * 48'(CYC_PER_UNIT);
    gap_done = st_ff.gap_cnt >= gap_need;
    if (!gap_done) begin
      nxt_st.gap_cnt = st_ff.gap_cnt + 48'h1;
    end
    if (wr_take && (paddr == mpc_pkg::ADDR_INTERVAL)
        && (pwdata == mpc_pkg::INTERVAL_RESET)) begin
      nxt_st.gap_cnt = 48'h0;
    end
    case (st_ff.rd_state)
      mpc_pkg::RD_IDLE: begin
        if (wr_take && (paddr == mpc_pkg::ADDR_READOUT)) begin
          nxt_st.lines_left = pwdata[7:0];
          nxt_st.line_idx = 8'h00;
          nxt_st.rd_state = mpc_pkg::RD_GAP;
        end
      end
      mpc_pkg::RD_GAP: begin
        if (gap_done) begin
          nxt_st.rd_state = mpc_pkg::RD_SEND;
        end
      end
      mpc_pkg::RD_SEND: begin
        nxt_st.strobe = 1'b1;
        nxt_st.gap_cnt = 48'h0;
        nxt_st.lines_left = st_ff.lines_left - 8'h01;
        if (st_ff.lines_left == 8'h01) begin
          nxt_st.rd_state = mpc_pkg::RD_IDLE;
        end else if (st_ff.paged) begin
          nxt_st.rd_state = mpc_pkg::RD_WAIT;
        end else begin
          nxt_st.rd_state = mpc_pkg::RD_GAP;
        end
      end
      mpc_pkg::RD_WAIT: begin
        if (wr_take && (paddr == mpc_pkg::ADDR_COMMAND)) begin
          if (pwdata[mpc_pkg::CMD_KEY_BACK]) begin
            nxt_st.lines_left = 8'h00;
            nxt_st.rd_state = mpc_pkg::RD_IDLE;
          end else if (pwdata[mpc_pkg::CMD_KEY_SPACE]) begin
            nxt_st.line_idx = st_ff.line_idx + 8'h01;
            nxt_st.rd_state = mpc_pkg::RD_GAP;
          end
        end
      end
      default: nxt_st.rd_state = mpc_pkg::RD_IDLE;
    endcase
    if ((st_ff.rd_state == mpc_pkg::RD_GAP) && st_ff.strobe) begin
      nxt_st.line_idx = st_ff.line_idx + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.inertia <= mpc_pkg::INERTIA_RST;
      st_ff.gain <= mpc_pkg::GAIN_RST;
      st_ff.accel <= mpc_pkg::ACCEL_RST;
      st_ff.decel <= mpc_pkg::DECEL_RST;
      st_ff.halt_decel <= mpc_pkg::HALT_DECEL_RST;
      st_ff.paged <= mpc_pkg::PAGED_RST;
      st_ff.mon_sel <= mpc_pkg::MON_SEL_RST;
      st_ff.mon_off <= mpc_pkg::MON_OFF_RST;
      st_ff.mon_span <= mpc_pkg::MON_SPAN_RST;
      st_ff.interval <= mpc_pkg::INTERVAL_RST;
      st_ff.speed <= mpc_pkg::SPEED_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pready               = st_ff.pready;
  assign prdata               = st_ff.prdata;
  assign pslverr              = st_ff.pslverr;
  assign servo_on             = st_ff.servo_on;
  assign halt_request         = st_ff.halting;
  assign applied_decel        = st_ff.applied;
  assign inertia_setting      = st_ff.inertia;
  assign servo_gain           = st_ff.gain;
  assign accel_for_moves      = st_ff.accel;
  assign decel_for_moves      = st_ff.decel;
  assign positioning_speed    = st_ff.speed;
  assign first_analog_select  = st_ff.mon_sel;
  assign first_monitor_offset = st_ff.mon_off;
  assign first_monitor_span   = st_ff.mon_span;
  assign first_analog_output  = st_ff.mon_out;
  assign line_strobe          = st_ff.strobe;
  assign line_index           = st_ff.line_idx;

endmodule : mpc_core

`default_nettype wire

// >>> rtl/mpc_pkg.sv
package mpc_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INERTIA    = 8'h00;
  localparam logic [7:0] ADDR_GAIN       = 8'h04;
  localparam logic [7:0] ADDR_ACCEL      = 8'h08;
  localparam logic [7:0] ADDR_DECEL      = 8'h0c;
  localparam logic [7:0] ADDR_HALT_DECEL = 8'h10;
  localparam logic [7:0] ADDR_PAGED      = 8'h14;
  localparam logic [7:0] ADDR_MON_SEL    = 8'h18;
  localparam logic [7:0] ADDR_MON_OFF    = 8'h1c;
  localparam logic [7:0] ADDR_MON_SPAN   = 8'h20;
  localparam logic [7:0] ADDR_INTERVAL   = 8'h24;
  localparam logic [7:0] ADDR_SPEED      = 8'h28;
  localparam logic [7:0] ADDR_COMMAND    = 8'h2c;
  localparam logic [7:0] ADDR_STATUS     = 8'h30;
  localparam logic [7:0] ADDR_IDENTITY   = 8'h34;
  localparam logic [7:0] ADDR_READOUT    = 8'h38;
  localparam logic [7:0] ADDR_APPLIED    = 8'h3c;

  // ---------------------------------------------------------------
  // Ranges and reset values (fixed point)
  // ---------------------------------------------------------------
  localparam logic [31:0] INERTIA_MAX    = 32'h003d_0900; // 0.001 kg m2
  localparam logic [31:0] INERTIA_RST    = 32'h0000_0000;
  localparam logic [31:0] GAIN_MAX       = 32'h0000_ffff;
  localparam logic [31:0] GAIN_RST       = 32'h0000_0000;
  localparam logic [31:0] ACC_MIN        = 32'h0000_0001; // 0.1 s-2
  localparam logic [31:0] ACC_MAX        = 32'h0000_1f40;
  localparam logic [31:0] ACCEL_RST      = 32'h0000_000a;
  localparam logic [31:0] DECEL_RST      = 32'h0000_0000;
  localparam logic [31:0] HALT_DECEL_RST = 32'h0000_0000;
  localparam logic        PAGED_RST      = 1'b1;
  localparam logic [8:0]  MON_SEL_RST    = 9'h000;
  localparam logic [7:0]  MON_CODE_MAX   = 8'h08;
  localparam logic [7:0]  NAMED_MAX      = 8'h0a;
  localparam int          MON_NAMED_BIT  = 8;
  localparam logic [31:0] MON_OFF_RST    = 32'h0000_0000; // 0.001 units
  localparam logic [31:0] MON_OFF_LIMIT  = 32'h0001_86a0;
  localparam logic [31:0] MON_OFF_RELOAD = 32'h0000_0000;
  localparam logic [31:0] MON_SPAN_RST   = 32'h0000_2710;
  localparam logic [31:0] MON_SPAN_MAX   = 32'h0001_86a0;
  localparam logic [31:0] MON_SPAN_RELOAD = 32'h0000_2710;
  localparam logic [31:0] INTERVAL_MAX   = 32'h0001_86a0; // 0.1 ms
  localparam logic [31:0] INTERVAL_RST   = 32'h0000_0000;
  localparam logic [31:0] INTERVAL_RESET = 32'hffff_ffff;
  localparam logic [31:0] SPEED_MIN      = 32'h0000_0001; // 0.001 s-1
  localparam logic [31:0] SPEED_MAX      = 32'h0000_2710;
  localparam logic [31:0] SPEED_RST      = 32'h0000_03e8;

  // ---------------------------------------------------------------
  // Command bit positions
  // ---------------------------------------------------------------
  localparam int CMD_HALT      = 0;
  localparam int CMD_SERVO_OFF = 1;
  localparam int CMD_SERVO_ON  = 2;
  localparam int CMD_IDENTITY  = 3;
  localparam int CMD_KEY_SPACE = 4;
  localparam int CMD_KEY_BACK  = 5;
  localparam int CMD_CLR_ERR   = 6;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CYC_PER_UNIT = 25000; // 0.1 ms at 4 ns

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_GAP  = 2'b01,
    RD_SEND = 2'b11,
    RD_WAIT = 2'b10
  } mpc_rd_type;

endpackage : mpc_pkg

// >>> rtl/mpc_top_note.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// >>> bench/mpc_motion_model.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_motion_model (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Requests
  input  wire logic          start,
  input  wire logic          halt_request,
  // Motion status
  output logic               busy,
  output logic [31:0]        cur_op_decel,
  output logic [143:0]       mon_quantity
);
  // A move keeps running until the block asks for a halt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy <= 1'b0;
    else if (halt_request) busy <= 1'b0;
    else if (start) busy <= 1'b1;
  end
  assign cur_op_decel = 32'h0000_0064;
  for (genvar k = 0; k < 9; k++) begin : g_q
    assign mon_quantity[16*k +: 16] = 16'h1000 + 16'(k);
  end
endmodule : mpc_motion_model
`default_nettype wire

// >>> bench/mpc_core_checker.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_core_checker (
  // Bus side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Motion side
  input wire logic        positioning_busy,
  input wire logic [31:0] cur_op_decel,
  input wire logic [31:0] applied_decel,
  input wire logic [31:0] inertia_setting,
  input wire logic [31:0] servo_gain,
  input wire logic [31:0] positioning_speed,
  input wire logic        servo_on,
  input wire logic        halt_request,
  input wire logic [8:0]  first_analog_select,
  input wire logic [31:0] first_monitor_offset,
  input wire logic [31:0] first_monitor_span,
  input wire logic        line_strobe
);
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_gain_clear: assert property (
    wr && paddr == mpc_pkg::ADDR_INERTIA && pwdata != inertia_setting &&
    pwdata <= mpc_pkg::INERTIA_MAX |=> servo_gain == 32'h0) else $error("gain kept");
  a_speed_refuse: assert property (
    wr && paddr == mpc_pkg::ADDR_SPEED && (pwdata > 32'h2710 || pwdata == 32'h0)
    |-> pslverr ##1 $stable(positioning_speed)) else $error("bad speed taken");
  a_speed_live: assert property (
    wr && paddr == mpc_pkg::ADDR_SPEED && pwdata <= 32'h2710 && pwdata != 32'h0
    |=> positioning_speed == $past(pwdata)) else $error("speed not updated");
  a_sel_reload: assert property (
    $changed(first_analog_select) |-> first_monitor_offset == 32'h0 &&
    first_monitor_span == 32'h2710) else $error("monitor not reloaded");
  a_servo_lock: assert property (
    wr && paddr == mpc_pkg::ADDR_COMMAND && pwdata[1] |=> ##1 !servo_on)
    else $error("servo on while locked");
  a_halt_cmd: assert property (
    wr && paddr == mpc_pkg::ADDR_COMMAND && pwdata[0] |-> ##[1:3] halt_request)
    else $error("halt not raised");
  a_decel_floor: assert property (
    $past(presetn) && !$past(positioning_busy) |-> applied_decel >= $past(cur_op_decel))
    else $error("halt decel too small");
  a_line_pulse: assert property (
    line_strobe |=> !line_strobe) else $error("line strobe too long");
endmodule : mpc_core_checker
bind mpc_core mpc_core_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .positioning_busy(positioning_busy), .cur_op_decel(cur_op_decel),
  .applied_decel(applied_decel), .inertia_setting(inertia_setting),
  .servo_gain(servo_gain), .positioning_speed(positioning_speed), .servo_on(servo_on),
  .halt_request(halt_request), .first_analog_select(first_analog_select),
  .first_monitor_offset(first_monitor_offset), .first_monitor_span(first_monitor_span),
  .line_strobe(line_strobe));
`default_nettype wire

// >>> bench/mpc_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_core_tb;
  localparam logic [15:0] MT = 16'h00a5; // Arbitrary value
  localparam logic [15:0] FW = 16'h0203; // Arbitrary value
  logic pclk, presetn, psel, penable, pwrite, stop_in, servo_enable_input_in, start, pready, pslverr;
  logic servo_on, halt_request, line_strobe, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, op_decel, mon_out, d;
  logic [143:0] mon_q;
  logic [32:0] exp_q[$];
  int fails, n_compared, nstr, seed;
  logic [7:0] ra [10] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
  logic [31:0] rv [10] = '{32'h0, 32'ha, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h2710, 32'h0,
                           32'h3e8};
  mpc_core #(.CYC_PER_UNIT(4), .MOTOR_TYPE(MT), .FW_VERSION(FW)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .stop_input(stop_in), .servo_enable_input(servo_enable_input_in), .positioning_busy(busy),
    .jog_busy(busy), .home_busy(busy), .program_busy(busy), .cur_op_decel(op_decel),
    .mon_quantity(mon_q), .servo_on(servo_on), .halt_request(halt_request),
    .applied_decel(), .inertia_setting(), .servo_gain(), .accel_for_moves(),
    .decel_for_moves(), .positioning_speed(), .first_analog_select(),
    .first_monitor_offset(), .first_monitor_span(), .first_analog_output(mon_out),
    .line_strobe(line_strobe), .line_index());
  mpc_motion_model u_far (.pclk(pclk), .presetn(presetn), .start(start),
    .halt_request(halt_request), .busy(busy), .cur_op_decel(op_decel), .mon_quantity(mon_q));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Idle cycle first: no strobe is assigned twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, ed,
                      input logic ee);
    exp_q.push_back({ee, ed});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic ee);
    xfer(1'b1, a, wd, 32'h0, ee);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic ee);
    xfer(1'b0, a, 32'h0, ed, ee);
  endtask : rd
  always @(posedge pclk) begin
    logic [32:0] e;
    if (line_strobe) nstr++;
    if (psel && penable && pready) begin
      e = exp_q.pop_front();
      chk(prdata, e[31:0]);
      chk(32'(pslverr), 32'(e[32]));
    end
  end
  task automatic close_out;
    $display("fails %0d compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    fails++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, stop_in, servo_enable_input_in, start} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    seed = 76;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i], 1'b0);
    wr(8'h04, 32'h5, 1'b0);
    wr(8'h00, 32'h64, 1'b0);
    rd(8'h04, 32'h0, 1'b0);
    wr(8'h00, 32'h003d_0901, 1'b1);
    rd(8'h00, 32'h64, 1'b0);
    wr(8'h08, 32'h0, 1'b1);
    wr(8'h0c, 32'h1f41, 1'b1);
    wr(8'h28, 32'h2711, 1'b1);
    rd(8'h40, 32'h0, 1'b1);
    for (int i = 1; i < 10; i++) begin
      wr(8'h1c, 32'h5, 1'b0);
      wr(8'h18, 32'(i % 9), 1'b0);
      rd(8'h1c, 32'h0, 1'b0);
      chk(mon_out, 32'h1000 + 32'(i % 9));
    end
    wr(8'h18, 32'h9, 1'b1);
    wr(8'h18, 32'h109, 1'b0);
    rd(8'h28, 32'h3e8, 1'b0);
    chk(mon_out, 32'h3e8);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    rd(8'h3c, 32'ha, 1'b0);
    wr(8'h0c, 32'h32, 1'b0);
    rd(8'h3c, 32'h32, 1'b0);
    wr(8'h10, 32'hc8, 1'b0);
    rd(8'h3c, 32'hc8, 1'b0);
    wr(8'h10, 32'h14, 1'b0);
    rd(8'h3c, 32'h32, 1'b0);
    wr(8'h2c, 32'h1, 1'b0);
    repeat (3) @(posedge pclk);
    chk(32'(busy), 32'h0);
    stop_in <= 1'b1;
    servo_enable_input_in <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(32'(halt_request), 32'h1);
    chk(32'(servo_on), 32'h1);
    stop_in <= 1'b0;
    wr(8'h2c, 32'h2, 1'b0);
    repeat (3) @(posedge pclk);
    chk(32'(servo_on), 32'h0);
    wr(8'h2c, 32'hc, 1'b0);
    rd(8'h34, {FW, MT}, 1'b0);
    chk(32'(servo_on), 32'h1);
    wr(8'h14, 32'h0, 1'b0);
    nstr = 0;
    wr(8'h38, 32'h3, 1'b0);
    repeat (40) @(posedge pclk);
    chk(32'(nstr), 32'h3);
    wr(8'h14, 32'h1, 1'b0);
    nstr = 0;
    wr(8'h38, 32'h2, 1'b0);
    repeat (20) @(posedge pclk);
    chk(32'(nstr), 32'h1);
    wr(8'h2c, 32'h10, 1'b0);
    repeat (20) @(posedge pclk);
    chk(32'(nstr), 32'h2);
    wr(8'h38, 32'h3, 1'b0);
    repeat (20) @(posedge pclk);
    wr(8'h2c, 32'h20, 1'b0);
    repeat (20) @(posedge pclk);
    chk(32'(nstr), 32'h3);
    wr(8'h24, 32'hffff_ffff, 1'b0);
    rd(8'h24, 32'h0, 1'b0);
    wr(8'h24, 32'h0001_86a1, 1'b1);
    repeat (4) begin
      d = $unsigned($random(seed)) % 32'h2710 + 32'h1;
      wr(8'h28, d, 1'b0);
      rd(8'h28, d, 1'b0);
    end
    close_out();
  end
endmodule : mpc_core_tb
`default_nettype wire
